// *** rtl/level_sync.sv ***
`timescale 1ns/1ps
module level_sync (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta;

  // Stage one feeds stage two only
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : level_sync

// *** rtl/modulo_step_counter.sv ***
`timescale 1ns/1ps
module modulo_step_counter (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input rotation_monitor_pkg::step_t step_in,
  input wire logic [23:0] modulus_in,
  input wire logic clear_in,
  output logic [23:0] count_out
);
  import rotation_monitor_pkg::*;

  logic [23:0] last;

  assign last = modulus_in - 24'h000001;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_out <= 24'h000000;
    end else if (clear_in) begin
      count_out <= 24'h000000;
    end else if (step_in.pulse) begin
      if (step_in.dir) begin
        count_out <= (count_out >= last) ? 24'h000000 : count_out + 24'h000001;
      end else begin
        count_out <= (count_out == 24'h000000) ? last : count_out - 24'h000001;
      end
    end
  end
endmodule : modulo_step_counter

// *** rtl/rotation_monitor_pkg.sv ***
package rotation_monitor_pkg;

  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [39:0] CLK_HZ_WIDE = 40'h0005F5E100;
  localparam int unsigned STEPS_W = 24;
  localparam int unsigned TOL_W = 24;
  localparam int unsigned FREQ_W = 20;
  localparam int unsigned IVL_W = 20;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned IRQ_W = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STEPS_REV = 6'h04;
  localparam logic [5:0] ADDR_EDGE_TOL = 6'h08;
  localparam logic [5:0] ADDR_MAX_FREQ = 6'h0C;
  localparam logic [5:0] ADDR_STATUS = 6'h10;
  localparam logic [5:0] ADDR_COUNT = 6'h14;
  localparam logic [5:0] ADDR_REF = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h20;
  localparam logic [5:0] ADDR_ACTIVE_STEPS = 6'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned IRQ_ROT_ERR_BIT = 0;
  localparam int unsigned IRQ_DRIVE_BIT = 1;
  localparam int unsigned IRQ_REF_BIT = 2;
  localparam int unsigned STATUS_ENABLE_BIT = 2;
  localparam int unsigned STATUS_REF_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [23:0] STEPS_DEFAULT = 24'h0007D0;
  localparam logic [23:0] STEPS_MIN = 24'h00000A;
  localparam logic [23:0] STEPS_MAX = 24'h989680;
  localparam logic [23:0] TOL_DEFAULT = 24'h000032;
  localparam logic [23:0] TOL_MIN = 24'h00000A;
  localparam logic [23:0] TOL_MAX = 24'h989680;
  localparam logic [19:0] FREQ_DEFAULT = 20'h3D090;
  localparam logic [19:0] FREQ_MIN = 20'h00064;
  localparam logic [19:0] FREQ_MAX = 20'hF4240;
  localparam logic [19:0] IVL_SAT = 20'hFFFFF;
  localparam logic [2:0] IRQ_MASK_DEFAULT = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pulse;
    logic dir;
  } step_t;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT_REF = 2'b01,
    ST_WATCH = 2'b10,
    ST_FAULT = 2'b11
  } mon_state_t;

endpackage : rotation_monitor_pkg

// *** rtl/stepper_rotation_monitor.sv ***
`timescale 1ns/1ps
module stepper_rotation_monitor (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [rotation_monitor_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input rotation_monitor_pkg::step_t step_in,
  input wire logic proximity_switch_in,
  input wire logic monitor_enable_in,
  output logic rot_error_out,
  output logic monitor_active_out,
  output logic irq_out
);
  import rotation_monitor_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      res[i*8 +: 8] = be[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  // Distance taken modulo the revolution, so a reference near zero still
  // accepts counts just below the wrap point.
  function automatic logic in_window(input logic [23:0] cnt,
                                     input logic [23:0] ref_val,
                                     input logic [23:0] modulus,
                                     input logic [23:0] tol);
    logic [24:0] diff;
    logic [24:0] back;
    diff = (cnt >= ref_val) ? {1'b0, cnt} - {1'b0, ref_val}
                            : {1'b0, cnt} + {1'b0, modulus} - {1'b0, ref_val};
    back = {1'b0, modulus} - diff;
    return (diff <= {1'b0, tol}) || (back <= {1'b0, tol});
  endfunction : in_window
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [23:0] pending_steps;
  logic [23:0] revolution_step_count;
  logic [23:0] edge_tolerance_steps;
  logic [19:0] max_step_frequency;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [23:0] zero_ref;
  logic [23:0] mod_count;
  logic ref_valid;
  mon_state_t state;
  mon_state_t next_state;
  logic monitor_enable_sync;
  logic switch_sync;
  logic switch_prev;
  logic switch_edge;
  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic bus_req;
  logic do_write;
  logic [31:0] wdata_merged;
  logic [31:0] rd_mux;
  logic restart;

  assign bus_req = avs_read_in | avs_write_in;
  // Writes act at the edge where waitrequest is seen low
  assign do_write = avs_write_in & ~avs_waitrequest_out;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_in)
      ADDR_CTRL: rd_mux = 32'h00000000;
      ADDR_STEPS_REV: rd_mux = {8'h00, pending_steps};
      ADDR_EDGE_TOL: rd_mux = {8'h00, edge_tolerance_steps};
      ADDR_MAX_FREQ: rd_mux = {12'h000, max_step_frequency};
      ADDR_STATUS: rd_mux = {28'h0000000, ref_valid, monitor_enable_sync, state};
      ADDR_COUNT: rd_mux = {8'h00, mod_count};
      ADDR_REF: rd_mux = {8'h00, zero_ref};
      ADDR_IRQ_STATUS: rd_mux = {29'h00000000, irq_status};
      ADDR_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
      ADDR_ACTIVE_STEPS: rd_mux = {8'h00, revolution_step_count};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & avs_waitrequest_out) begin
      avs_readdata_out <= rd_mux;
    end
  end
  // Disabled bytes keep the stored value, or count as zero for write-one-to-clear
  assign wdata_merged = merge_bytes((avs_address_in == ADDR_IRQ_STATUS) ? 32'h00000000 : rd_mux,
                                    avs_writedata_in, avs_byteenable_in);
  assign restart = do_write && (avs_address_in == ADDR_CTRL) && wdata_merged[CTRL_RESTART_BIT];
  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Out-of-range writes are dropped, so the stored values always stay legal
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pending_steps <= STEPS_DEFAULT;
    end else if (do_write && avs_address_in == ADDR_STEPS_REV &&
                 wdata_merged[31:24] == 8'h00 && wdata_merged[23:0] >= STEPS_MIN &&
                 wdata_merged[23:0] <= STEPS_MAX) begin
      pending_steps <= wdata_merged[23:0];
    end
  end
  // Counter modulus only changes on restart, never mid-revolution
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      revolution_step_count <= STEPS_DEFAULT;
    end else if (restart) begin
      revolution_step_count <= pending_steps;
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      edge_tolerance_steps <= TOL_DEFAULT;
    end else if (do_write && avs_address_in == ADDR_EDGE_TOL &&
                 wdata_merged[31:24] == 8'h00 && wdata_merged[23:0] >= TOL_MIN &&
                 wdata_merged[23:0] <= TOL_MAX) begin
      edge_tolerance_steps <= wdata_merged[23:0];
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      max_step_frequency <= FREQ_DEFAULT;
    end else if (do_write && avs_address_in == ADDR_MAX_FREQ &&
                 wdata_merged[31:20] == 12'h000 && wdata_merged[19:0] >= FREQ_MIN &&
                 wdata_merged[19:0] <= FREQ_MAX) begin
      max_step_frequency <= wdata_merged[19:0];
    end
  end
  // ----------------------------------------------------------------
  // Inputs from outside the clock domain
  // ----------------------------------------------------------------
  level_sync u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .async_in({monitor_enable_in, proximity_switch_in}),
    .sync_out({monitor_enable_sync, switch_sync})
  );
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      switch_prev <= 1'b0;
    end else begin
      switch_prev <= switch_sync;
    end
  end
  // Only the rising edge counts; the falling edge would move with switch hysteresis
  assign switch_edge = switch_sync & ~switch_prev;
  // ----------------------------------------------------------------
  // Revolution counter
  // ----------------------------------------------------------------
  modulo_step_counter u_counter (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .step_in(step_in),
    .modulus_in(revolution_step_count),
    .clear_in(restart),
    .count_out(mod_count)
  );
  // ----------------------------------------------------------------
  // Drive control check
  // ----------------------------------------------------------------
  logic [IVL_W-1:0] step_interval;
  logic step_seen;
  logic [39:0] interval_product;
  logic drive_fault;
  assign interval_product = step_interval * max_step_frequency;
  // Steps closer than one period of the limit frequency mean bad drive control
  assign drive_fault = step_in.pulse & step_seen & (interval_product < CLK_HZ_WIDE);
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step_interval <= IVL_SAT;
      step_seen <= 1'b0;
    end else if (restart) begin
      step_interval <= IVL_SAT;
      step_seen <= 1'b0;
    end else if (step_in.pulse) begin
      step_interval <= 20'h00001;
      step_seen <= 1'b1;
    end else if (step_interval != IVL_SAT) begin
      step_interval <= step_interval + 20'h00001;
    end
  end
  // ----------------------------------------------------------------
  // Monitor sequence
  // ----------------------------------------------------------------
  logic edge_ok;
  logic tol_fail;
  logic ref_capture;
  assign edge_ok = in_window(mod_count, zero_ref, revolution_step_count,
                             edge_tolerance_steps);
  assign tol_fail = (state == ST_WATCH) && monitor_enable_sync && switch_edge && !edge_ok;
  assign ref_capture = (state == ST_WAIT_REF) && monitor_enable_sync && switch_edge;
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (monitor_enable_sync && !drive_fault) begin
          next_state = ST_WAIT_REF;
        end
      end
      ST_WAIT_REF: begin
        if (!monitor_enable_sync) begin
          next_state = ST_OFF;
        end else if (drive_fault) begin
          next_state = ST_FAULT;
        end else if (ref_capture) begin
          next_state = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (!monitor_enable_sync) begin
          next_state = ST_OFF;
        end else if (tol_fail || drive_fault) begin
          next_state = ST_FAULT;
        end
      end
      // Stays off until the PLC drops enable or a restart is written, forcing a fresh reference
      ST_FAULT: begin
        if (!monitor_enable_sync) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_OFF;
    end else if (restart) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_ref <= 24'h000000;
      ref_valid <= 1'b0;
    end else if (restart || next_state == ST_OFF || next_state == ST_FAULT) begin
      ref_valid <= 1'b0;
    end else if (ref_capture) begin
      zero_ref <= mod_count;
      ref_valid <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Outputs toward the PLC
  // ----------------------------------------------------------------
  // Single-cycle pulse; the PLC evaluates it on the edge
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rot_error_out <= 1'b0;
    end else begin
      rot_error_out <= tol_fail | drive_fault;
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      monitor_active_out <= 1'b0;
    end else begin
      monitor_active_out <= !restart && ((next_state == ST_WAIT_REF) || (next_state == ST_WATCH));
    end
  end
  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_set = {ref_capture, drive_fault, tol_fail};
  assign irq_clr = (do_write && avs_address_in == ADDR_IRQ_STATUS) ? wdata_merged[IRQ_W-1:0]
                                                                    : 3'h0;
  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_mask <= IRQ_MASK_DEFAULT;
    end else if (do_write && avs_address_in == ADDR_IRQ_MASK) begin
      irq_mask <= wdata_merged[IRQ_W-1:0];
    end
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

endmodule : stepper_rotation_monitor

// *** tb/motor_switch_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Stepper drive with a switch on the shaft
// ----------------------------------------------------------------
module motor_switch_model #(
  parameter int N = 40,
  parameter int SW_POS = 38
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic go_in,
  input wire logic [7:0] n_in,
  input wire logic [7:0] lost_in,
  input wire logic [15:0] gap_in,
  input wire logic dir_in,
  input wire logic rot_error_in,
  output rotation_monitor_pkg::step_t step_out,
  output logic switch_out,
  output logic busy_out
);
  import rotation_monitor_pkg::*;
  int pos;
  int left;
  int lost;
  int tick;
  logic drive_off;
  // Lost steps: the pulse goes out but the shaft stays put
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pos <= 0;
      left <= 0;
      lost <= 0;
      tick <= 0;
      drive_off <= 1'h0;
      step_out <= '0;
    end else begin
      step_out <= '0;
      if (go_in) begin
        left <= int'(n_in);
        lost <= int'(lost_in);
        tick <= int'(gap_in);
        drive_off <= 1'h0;
      end else if (rot_error_in) begin
        drive_off <= 1'h1;
      end else if (left > 0 && !drive_off) begin
        if (tick > 1) begin
          tick <= tick - 1;
        end else begin
          tick <= int'(gap_in);
          left <= left - 1;
          step_out <= '{pulse: 1'h1, dir: dir_in};
          if (lost > 0) begin
            lost <= lost - 1;
          end else begin
            pos <= dir_in ? (pos + 1) % N : (pos + N - 1) % N;
          end
        end
      end
    end
  end
  // One closed position per turn, a true level otherwise
  assign switch_out = (pos == SW_POS);
  assign busy_out = (left > 0) && !drive_off;
endmodule : motor_switch_model

// *** tb/rotation_monitor_asserts.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------
module rotation_monitor_asserts (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [rotation_monitor_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input rotation_monitor_pkg::step_t step_in,
  input wire logic proximity_switch_in,
  input wire logic monitor_enable_in,
  input wire logic rot_error_out,
  input wire logic monitor_active_out,
  input wire logic irq_out
);
  import rotation_monitor_pkg::*;
  logic sw_q;
  logic [3:0] since_evt;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  // Errors need a recent step or switch rise as cause; interrupts may also follow a recent write
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sw_q <= 1'h0;
      since_evt <= 4'hF;
    end else begin
      sw_q <= proximity_switch_in;
      if (step_in.pulse || (proximity_switch_in && !sw_q)) begin
        since_evt <= 4'h0;
      end else if (since_evt != 4'hF) begin
        since_evt <= since_evt + 4'h1;
      end
    end
  end
  sequence en_off_s;
    !monitor_enable_in [*4];
  endsequence
  sequence en_on_s;
    (monitor_enable_in && !rot_error_out) [*4];
  endsequence
  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no answer one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  err_pulse_a: assert property (rot_error_out |=> !rot_error_out)
    else $error("error output wider than one cycle");
  err_stops_a: assert property (rot_error_out |-> !monitor_active_out)
    else $error("monitor still active after error");
  en_gate_a: assert property (!monitor_enable_in [*5] |-> !monitor_active_out)
    else $error("monitor active while enable low");
  en_starts_a: assert property (en_off_s ##1 en_on_s |-> monitor_active_out)
    else $error("monitor not started by enable");
  err_cause_a: assert property (rot_error_out |-> since_evt <= 4'h8)
    else $error("error without step or switch cause");
  irq_cause_a: assert property ($rose(irq_out) |-> since_evt <= 4'hA
    || $past(avs_write_in) || $past(avs_write_in, 2)) else $error("irq rose without cause");
  irq_clear_a: assert property ($fell(irq_out) |-> $past(avs_write_in)
    || $past(avs_write_in, 2)) else $error("irq fell without a write");
endmodule : rotation_monitor_asserts

bind stepper_rotation_monitor rotation_monitor_asserts i_rotation_monitor_asserts (
  .mclk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .step_in,
  .proximity_switch_in, .monitor_enable_in, .rot_error_out, .monitor_active_out, .irq_out);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rotation_monitor_pkg::*;
  typedef struct packed {
    logic wr;
    logic [5:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic mclk_in;
  logic nrst_in;
  logic [ADDR_W-1:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  step_t step;
  logic sw;
  logic monitor_enable_in;
  logic rot_error_out;
  logic monitor_active_out;
  logic irq_out;
  logic go;
  logic [7:0] n_steps;
  logic [7:0] n_lost;
  logic [15:0] gap;
  logic busy;
  logic dir;
  logic [31:0] q;
  int errors;
  int check_count;
  int err_hi;
  row_t rows [16] = '{
    '{1'h0, ADDR_STEPS_REV, 32'h0, 32'h7D0}, '{1'h0, ADDR_EDGE_TOL, 32'h0, 32'h32},
    '{1'h0, ADDR_MAX_FREQ, 32'h0, 32'h3D090}, '{1'h0, 6'h28, 32'h0, 32'h0},
    '{1'h0, ADDR_IRQ_MASK, 32'h0, 32'h0}, '{1'h1, ADDR_STATUS, 32'hF, 32'h0},
    '{1'h1, ADDR_STEPS_REV, 32'h9, 32'h7D0}, '{1'h1, ADDR_STEPS_REV, 32'h989681, 32'h7D0},
    '{1'h1, ADDR_EDGE_TOL, 32'h9, 32'h32}, '{1'h1, ADDR_MAX_FREQ, 32'h63, 32'h3D090},
    '{1'h1, ADDR_MAX_FREQ, 32'hF4241, 32'h3D090}, '{1'h1, ADDR_MAX_FREQ, 32'hF4240, 32'hF4240},
    '{1'h1, ADDR_EDGE_TOL, 32'hA, 32'hA}, '{1'h1, ADDR_STEPS_REV, 32'h28, 32'h28},
    '{1'h1, 6'h28, 32'h1234, 32'h0}, '{1'h1, ADDR_IRQ_MASK, 32'h7, 32'h7}};

  stepper_rotation_monitor i_stepper_rotation_monitor (
    .mclk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .step_in(step),
    .proximity_switch_in(sw), .monitor_enable_in, .rot_error_out, .monitor_active_out,
    .irq_out);
  motor_switch_model i_motor_switch_model (.mclk_in, .nrst_in, .go_in(go), .n_in(n_steps),
    .lost_in(n_lost), .gap_in(gap), .rot_error_in(rot_error_out), .step_out(step),
    .dir_in(dir), .switch_out(sw), .busy_out(busy));

  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (rot_error_out === 1'h1) err_hi++;

  task automatic complete_run;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    errors++;
    $display("ERROR %0t wait ran out", $time);
    complete_run();
  endtask : hang
  task automatic av(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'h0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    if (n >= 50) hang();
  endtask : av
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  task automatic run(input logic [7:0] n, input logic [7:0] lost, input logic [15:0] g);
    int k;
    @(posedge mclk_in);
    n_steps <= n;
    n_lost <= lost;
    gap <= g;
    go <= 1'h1;
    @(posedge mclk_in);
    go <= 1'h0;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (busy !== 1'h0 && k < 20000);
    if (k >= 20000) hang();
    cyc(8);
  endtask : run

  initial begin
    mclk_in = 1'h0;
    nrst_in = 1'h0;
    avs_address_in = '0;
    avs_read_in = 1'h0;
    avs_write_in = 1'h0;
    avs_writedata_in = '0;
    avs_byteenable_in = 4'hF;
    monitor_enable_in = 1'h0;
    go = 1'h0;
    n_steps = '0;
    n_lost = '0;
    gap = 16'h78;
    dir = 1'h1;
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].wr) av(1'h1, rows[i].a, rows[i].d);
      av(1'h0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    av(1'h0, ADDR_ACTIVE_STEPS, 32'h0);
    chk(q, 32'h7D0);
    // Restart with monitoring off, so no stale edge is judged
    av(1'h1, ADDR_CTRL, 32'h1);
    av(1'h0, ADDR_ACTIVE_STEPS, 32'h0);
    chk(q, 32'h28);
    monitor_enable_in <= 1'h1;
    cyc(5);
    chk(monitor_active_out, 32'h1);
    run(8'h26, 8'h0, 16'h78);
    av(1'h0, ADDR_REF, 32'h0);
    chk(q, 32'h26);
    av(1'h0, ADDR_STATUS, 32'h0);
    chk(q, 32'hE);
    run(8'h32, 8'hA, 16'h78);
    av(1'h0, ADDR_COUNT, 32'h0);
    chk(q, 32'h8);
    chk(err_hi, 32'h0);
    run(8'h2D, 8'h1, 16'h78);
    chk(err_hi, 32'h1);
    av(1'h0, ADDR_COUNT, 32'h0);
    chk(q, 32'h9);
    chk(monitor_active_out, 32'h0);
    av(1'h0, ADDR_STATUS, 32'h0);
    chk(q & 32'h3, 32'h3);
    av(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(q, 32'h5);
    chk(irq_out, 32'h1);
    av(1'h1, ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk(irq_out, 32'h0);
    av(1'h1, ADDR_IRQ_STATUS, 32'h7);
    av(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(q, 32'h0);
    av(1'h1, ADDR_IRQ_MASK, 32'h7);
    run(8'h28, 8'h0, 16'h78);
    chk(err_hi, 32'h1);
    monitor_enable_in <= 1'h0;
    cyc(5);
    monitor_enable_in <= 1'h1;
    cyc(5);
    chk(monitor_active_out, 32'h1);
    monitor_enable_in <= 1'h0;
    cyc(5);
    run(8'h2, 8'h0, 16'h32);
    chk(err_hi, 32'h2);
    av(1'h0, ADDR_IRQ_STATUS, 32'h0);
    chk(q, 32'h2);
    chk(irq_out, 32'h1);
    nrst_in <= 1'h0;
    cyc(2);
    chk({avs_waitrequest_out, irq_out, monitor_active_out, rot_error_out}, 32'h8);
    nrst_in <= 1'h1;
    av(1'h0, ADDR_ACTIVE_STEPS, 32'h0);
    chk(q, 32'h7D0);
    av(1'h0, ADDR_EDGE_TOL, 32'h0);
    chk(q, 32'h32);
    // One step down from zero must wrap to the top of the revolution
    dir <= 1'h0;
    run(8'h1, 8'h0, 16'h78);
    av(1'h0, ADDR_COUNT, 32'h0);
    chk(q, 32'h7CF);
    complete_run();
  end
endmodule : tb_top
